// ---- core/sdc_pkg.sv ----
// What this block does
// [RULE_01] Host holds command-select high for the whole command-register write.
// [RULE_02] Register transfers happen only with command-select low; low means data transfer.
// [RULE_03] Host keeps command-select high through chip-select rising edge ending command.
// [RULE_04] During a command write the fault byte of status shifts out.
// [RULE_05] Later data transfers keep the last command's direction, bank and length.
// [RULE_06] Command bit 7: zero makes follow-on reads, one makes writes.
// [RULE_07] Host writes zeros into reserved command bits 6 and 5.
// [RULE_08] Command bits 4 to 1 address the register bank.
// [RULE_09] Command bit 0 set: 8-bit top-byte access; clear: full 32 bits.
// [RULE_10] Status bits 31 to 24 are per-channel on bits.
// [RULE_11] Status bits 23 to 16 hold fault masks and master frequency select.
// [RULE_12] Status bits 15 to 8 hold pair parallel or bridge configuration.
// [RULE_13] Status bits 7 to 0: seven read-only flags plus active bit, zero at reset.
// [RULE_14] Active bit low keeps the device idle with all outputs three-stated.
// [RULE_15] Undervoltage flag set at power-up, cleared by status read; blocks operation.
// [RULE_16] Summary flags set when any channel reports; own temperature and link-error flags.
// [RULE_17] Host checks returned fault byte; link-error code means redo programming.
// [RULE_18] Host init order: read status, write status, write configs, read status.
// [RULE_19] Each access is a command write then a data transfer.
// [RULE_20] Mode and side bits change only with channels off and triggers low.
// [RULE_21] Single-byte config top-byte write updates hold current at once.
// [RULE_22] Host toggles channels by single-byte write of status top byte.
// [RULE_23] Link is mode zero: sample on rising clock, clock idles low.
// [RULE_24] Link supports daisy chains at up to 5 MHz; the code takes only 8- or 32-clock frames and passes no data through.
// [RULE_25] Transfers shift MSB first; length 8 for command, 8 or 32 for data.
package sdc_pkg;
    localparam int SDC_NCH = 8;
    // Command field positions
    localparam int SDC_CMD_DIR_BIT = 7;
    localparam int SDC_CMD_BANK_HI = 4;
    localparam int SDC_CMD_BANK_LO = 1;
    localparam int SDC_CMD_SHORT_BIT = 0;
    // Bank addresses
    localparam logic [3:0] SDC_BANK_STATUS = 4'h0;
    localparam logic [3:0] SDC_BANK_CFG_FIRST = 4'h1;
    localparam logic [3:0] SDC_BANK_CFG_LAST = 4'h8;
    localparam logic [3:0] SDC_BANK_FAULT = 4'h9;
    // Status field positions
    localparam int SDC_ST_ON_LO = 24;
    localparam int SDC_ST_MASK_LO = 16;
    localparam int SDC_ST_PAIR_LO = 8;
    localparam int SDC_ST_ACTIVE_BIT = 0;
    // Flag bit positions inside the fault byte
    localparam int SDC_FL_OVT = 7;
    localparam int SDC_FL_OCP = 6;
    localparam int SDC_FL_OLF = 5;
    localparam int SDC_FL_HHF = 4;
    localparam int SDC_FL_DPM = 3;
    localparam int SDC_FL_COM = 2;
    localparam int SDC_FL_UVM = 1;
    // Reset values
    localparam logic [31:0] SDC_STATUS_RST = 32'h0000_0002;
    localparam logic [31:0] SDC_CFG_RST = 32'h0000_0000;
    // Config low-byte bits that may change only when idle
    localparam logic [31:0] SDC_CFG_LOCK_MASK = 32'h0000_0003;
    localparam int SDC_LEN_CMD = 8;
    localparam int SDC_LEN_SHORT = 8;
    localparam int SDC_LEN_LONG = 32;

    // Latched command
    typedef struct packed {
        logic write;
        logic [3:0] bank;
        logic short_xfer;
    } sdc_cmd_t;

    // Per-channel fault reports from the analogue side
    typedef struct packed {
        logic [SDC_NCH-1:0] overcurrent_flag;
        logic [SDC_NCH-1:0] open_load_flag;
        logic [SDC_NCH-1:0] hit_not_reached_flag;
        logic [SDC_NCH-1:0] plunger_movement_flag;
    } sdc_fault_t;
endpackage

// ---- core/sdc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_top #(
    parameter int NCH = sdc_pkg::SDC_NCH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic link_sck,
    input wire logic chip_select_bar,
    input wire logic cmd_select,
    input wire logic link_sdi,
    output logic link_sdo,
    output logic link_sdo_oe,
    // Fault sources and trigger inputs
    input wire sdc_pkg::sdc_fault_t chan_faults,
    input wire logic overtemp_in,
    input wire logic undervoltage_in,
    input wire logic trigger_input_a,
    input wire logic trigger_input_b,
    // Drive side
    output logic [NCH-1:0] channel_enable,
    output logic outputs_hiz,
    output logic [7:0] fault_mask,
    output logic [7:0] pair_config,
    output logic [NCH*32-1:0] channel_config,
    output logic fault_indicator_pin
);
    import sdc_pkg::*;

    // Elaboration guard: bank decode, fault byte and fault view assume eight channels
    if (NCH != 8) begin : g_nch_check
        $error("sdc_top supports eight channels only");
    end

    // Two-flop synchronisers on all link pins
    // Clock, select, command and data pass together, so their order is kept
    // Each link clock level must last a few system clocks; at 100 MHz this
    // leaves ample margin over the daisy-chain link rate
    logic [3:0] s1_r, s2_r;
    logic sck_d_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Preset to idle pins: clock low, deselected, data frame
            // Avoids a false clock edge straight after reset
            s1_r <= 4'h4;
            s2_r <= 4'h4;
            sck_d_r <= 1'b0;
        end else begin
            s1_r <= {link_sck, chip_select_bar, cmd_select, link_sdi}; // [RULE_24]
            s2_r <= s1_r;
            sck_d_r <= s2_r[3];
        end
    end
    wire sck_s = s2_r[3];
    wire csb_s = s2_r[2];
    wire cmd_s = s2_r[1];
    wire sdi_s = s2_r[0];

    // Chip-select edges and link clock edges
    // Clock edges count only inside a frame, so a host that leaves the
    // clock running between frames shifts nothing
    logic csb_d_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csb_d_r <= 1'b1;
        end else begin
            csb_d_r <= csb_s;
        end
    end
    wire frame_start = csb_d_r & ~csb_s;
    wire frame_end = ~csb_d_r & csb_s;
    wire sck_rise = ~sck_d_r & sck_s & ~csb_s; // [RULE_23]
    wire sck_fall = sck_d_r & ~sck_s & ~csb_s;

    // Frame state
    logic [31:0] rx_r;
    logic [31:0] tx_r;
    logic [5:0] cnt_r;
    logic cmd_frame_r;
    logic cmd_drop_r;
    sdc_cmd_t cmd_r;
    logic cmd_valid_r;

    // Expected length for this frame
    // A frame of any other length is dropped, and flagged as a link error if it had at least one clock
    wire [5:0] data_len = cmd_r.short_xfer ? 6'(SDC_LEN_SHORT) : 6'(SDC_LEN_LONG); // [RULE_09]
    wire [5:0] frame_len = cmd_frame_r ? 6'(SDC_LEN_CMD) : data_len; // [RULE_25]
    wire len_ok = (cnt_r == frame_len);

    // Register storage
    logic [31:0] status_r;
    logic [31:0] cfg_r [NCH];
    logic ocp_seen_r, olf_seen_r, hhf_seen_r, dpm_seen_r, ovt_seen_r, com_r;
    logic [NCH-1:0] fault_ocp_r, fault_olf_r, fault_hhf_r, fault_dpm_r;

    // Bank decode
    // Unmapped banks read as zero and ignore writes
    wire bank_is_status = (cmd_r.bank == SDC_BANK_STATUS);
    wire bank_is_cfg = (cmd_r.bank >= SDC_BANK_CFG_FIRST) && (cmd_r.bank <= SDC_BANK_CFG_LAST);
    wire bank_is_fault = (cmd_r.bank == SDC_BANK_FAULT);
    wire [2:0] cfg_idx = 3'(cmd_r.bank - SDC_BANK_CFG_FIRST);
    wire [7:0] flag_byte = {ovt_seen_r, ocp_seen_r, olf_seen_r, hhf_seen_r, dpm_seen_r, com_r,
                            status_r[SDC_FL_UVM], status_r[SDC_ST_ACTIVE_BIT]};
    wire [31:0] status_view = {status_r[31:8], flag_byte};
    wire [31:0] fault_view = {fault_ocp_r, fault_hhf_r, fault_olf_r, fault_dpm_r};
    wire [31:0] read_word = bank_is_status ? status_view :
                            bank_is_cfg ? cfg_r[cfg_idx] :
                            bank_is_fault ? fault_view : 32'h0000_0000;
    // Short reads present the top byte first on the wire
    wire [31:0] load_word = cmd_s ? {flag_byte, 24'h00_0000} : read_word; // [RULE_04]

    // Completed transfers
    // Registers change only once chip select has risen on a clean frame,
    // so a frame cut short never leaves a register half written
    wire good_end = frame_end & ~cmd_drop_r & len_ok;
    wire cmd_done = good_end & cmd_frame_r; // [RULE_03]
    wire data_done = good_end & ~cmd_frame_r & cmd_valid_r; // [RULE_02]
    wire bad_end = frame_end & (cmd_drop_r | ~len_ok) & (cnt_r != 6'h00);
    wire wr_done = data_done & cmd_r.write; // [RULE_06]
    wire rd_done = data_done & ~cmd_r.write;
    // Short writes reach only the top byte
    wire [31:0] wr_mask = cmd_r.short_xfer ? 32'hff00_0000 : 32'hffff_ffff;
    wire [31:0] wr_word = cmd_r.short_xfer ? {rx_r[7:0], 24'h00_0000} : rx_r;

    // Idle condition that unlocks mode and side bits
    // Only those two bits are held; the rest of the bank still lands
    wire all_off = (status_r[31:24] == 8'h00) & ~trigger_input_a & ~trigger_input_b; // [RULE_20]
    wire [31:0] cfg_keep = all_off ? wr_mask : (wr_mask & ~SDC_CFG_LOCK_MASK);

    // Shift engine: sample on rise, launch on fall
    // Read data loads at the chip-select fall, so the first bit is on the
    // line before the first rising clock edge, as mode zero needs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_r <= 32'h0000_0000;
            tx_r <= 32'h0000_0000;
            cnt_r <= 6'h00;
            cmd_frame_r <= 1'b0;
            cmd_drop_r <= 1'b0;
        end else if (frame_start) begin
            cnt_r <= 6'h00;
            cmd_frame_r <= cmd_s;
            cmd_drop_r <= 1'b0;
            tx_r <= load_word;
        end else begin
            if (sck_rise) begin
                rx_r <= {rx_r[30:0], sdi_s}; // [RULE_25]
                if (cnt_r != 6'h3f) begin
                    cnt_r <= cnt_r + 6'h01;
                end
            end
            if (sck_fall) begin
                tx_r <= {tx_r[30:0], 1'b0};
            end
            // Command-select must stay constant over the frame
            if (!csb_s && (cmd_s != cmd_frame_r)) begin
                cmd_drop_r <= 1'b1; // [RULE_01]
            end
        end
    end

    // Command register
    // A refused command frame leaves the previous command in force
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= '0;
            cmd_valid_r <= 1'b0;
        end else if (cmd_done) begin
            cmd_r.write <= rx_r[SDC_CMD_DIR_BIT]; // [RULE_06]
            cmd_r.bank <= rx_r[SDC_CMD_BANK_HI:SDC_CMD_BANK_LO]; // [RULE_08]
            cmd_r.short_xfer <= rx_r[SDC_CMD_SHORT_BIT]; // [RULE_09]
            cmd_valid_r <= 1'b1; // [RULE_05]
        end
    end

    // Status register, control fields
    // Short writes reach only the on bits; the active bit needs a full write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= SDC_STATUS_RST; // [RULE_13]
        end else begin
            if (wr_done && bank_is_status) begin
                status_r[31:8] <= (status_r[31:8] & ~wr_mask[31:8]) | (wr_word[31:8] & wr_mask[31:8]); // [RULE_10]
                if (!cmd_r.short_xfer) begin
                    status_r[SDC_ST_ACTIVE_BIT] <= wr_word[SDC_ST_ACTIVE_BIT]; // [RULE_13]
                end
            end
            // Set beats clear: a live undervoltage holds the flag
            if (undervoltage_in) begin
                status_r[SDC_FL_UVM] <= 1'b1;
            end else if (rd_done && bank_is_status) begin
                status_r[SDC_FL_UVM] <= 1'b0; // [RULE_15]
            end
            // Overcurrent drops the channel on bit
            for (int i = 0; i < NCH; i++) begin
                if (chan_faults.overcurrent_flag[i]) begin
                    status_r[SDC_ST_ON_LO + i] <= 1'b0;
                end
            end
        end
    end

    // Configuration banks
    // A short write changes only the top byte, even while the channel holds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_r[i] <= SDC_CFG_RST;
            end
        end else if (wr_done && bank_is_cfg) begin
            cfg_r[cfg_idx] <= (cfg_r[cfg_idx] & ~cfg_keep) | (wr_word & cfg_keep); // [RULE_21]
        end
    end

    // Summary flags: sticky, set wins over the read clear
    wire st_read = rd_done & bank_is_status;
    wire ft_read = rd_done & bank_is_fault;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ocp_seen_r <= 1'b0;
            olf_seen_r <= 1'b0;
            hhf_seen_r <= 1'b0;
            dpm_seen_r <= 1'b0;
            ovt_seen_r <= 1'b0;
            com_r <= 1'b0;
        end else begin
            ocp_seen_r <= (|chan_faults.overcurrent_flag) | (ocp_seen_r & ~st_read & ~ft_read); // [RULE_16]
            olf_seen_r <= (|chan_faults.open_load_flag) | (olf_seen_r & ~st_read & ~ft_read);
            hhf_seen_r <= (|chan_faults.hit_not_reached_flag) | (hhf_seen_r & ~st_read & ~ft_read);
            dpm_seen_r <= (|chan_faults.plunger_movement_flag) | (dpm_seen_r & ~st_read & ~ft_read);
            ovt_seen_r <= overtemp_in | (ovt_seen_r & ~st_read);
            // Malformed frames and data before any command are link errors
            com_r <= bad_end | (good_end & ~cmd_frame_r & ~cmd_valid_r) | (com_r & ~st_read);
        end
    end

    // Per-channel fault detail, cleared by a fault-bank read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_ocp_r <= '0;
            fault_olf_r <= '0;
            fault_hhf_r <= '0;
            fault_dpm_r <= '0;
        end else begin
            fault_ocp_r <= chan_faults.overcurrent_flag | (fault_ocp_r & {NCH{~ft_read}});
            fault_olf_r <= chan_faults.open_load_flag | (fault_olf_r & {NCH{~ft_read}});
            fault_hhf_r <= chan_faults.hit_not_reached_flag | (fault_hhf_r & {NCH{~ft_read}});
            fault_dpm_r <= chan_faults.plunger_movement_flag | (fault_dpm_r & {NCH{~ft_read}});
        end
    end

    // Drive enables: inactive or undervoltage pending keeps everything off
    // Registered so the drive side never sees a glitch from the decode
    wire run_ok = status_r[SDC_ST_ACTIVE_BIT] & ~status_r[SDC_FL_UVM]; // [RULE_14]
    // Link error is never routed to the fault pin
    wire [6:0] raw_flags = {ovt_seen_r, ocp_seen_r, olf_seen_r, hhf_seen_r, dpm_seen_r, 1'b0,
                            status_r[SDC_FL_UVM]};
    wire [6:0] mask_bits = status_r[SDC_ST_MASK_LO +: 7];
    wire fault_any = |(raw_flags & ~mask_bits);
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cfg
            always_comb channel_config[g*32 +: 32] = cfg_r[g];
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_enable <= '0;
            outputs_hiz <= 1'b1;
            fault_indicator_pin <= 1'b1;
        end else begin
            channel_enable <= run_ok ? status_r[31:24] : '0; // [RULE_10]
            outputs_hiz <= ~run_ok; // [RULE_14]
            fault_indicator_pin <= ~fault_any;
        end
    end
    assign fault_mask = status_r[23:16]; // [RULE_11]
    assign pair_config = status_r[15:8]; // [RULE_12]
    // Output drives only inside a frame so chained parts share the line
    assign link_sdo = tx_r[31];
    assign link_sdo_oe = ~csb_s;
endmodule
`default_nettype wire

// ---- tb/sdc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Link controller model: mode zero, 80 ns clock, MSB first
module sdc_host (
    // Pacing clock
    input wire logic clk,
    // Link pins
    output logic link_sck,
    output logic chip_select_bar,
    output logic cmd_select,
    output logic link_sdi,
    input wire logic link_sdo
);
    // Idle link: clock low, deselected
    initial begin
        link_sck = 1'b0;
        chip_select_bar = 1'b1;
        cmd_select = 1'b0;
        link_sdi = 1'b0;
    end
    // One frame: each clock level lasts 40 ns, an 80 ns link clock period
    task automatic frame(input logic cs, input logic [31:0] d, input int n, output logic [31:0] q);
        q = '0;
        @(negedge clk);
        cmd_select = cs;
        chip_select_bar = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            link_sdi = d[i];
            repeat (4) @(negedge clk);
            link_sck = 1'b1;
            // Sample late so the device's resync delay is covered
            repeat (2) @(negedge clk);
            q = {q[30:0], link_sdo};
            repeat (2) @(negedge clk);
            link_sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        chip_select_bar = 1'b1;
        link_sdi = ~link_sdi;
        repeat (8) @(negedge clk);
    endtask
    // Command frame then data frame
    task automatic acc(input logic [7:0] c, input logic [31:0] d, output logic [7:0] fb, output logic [31:0] q);
        frame(1'b1, {24'h0, c}, 8, q);
        fb = q[7:0];
        frame(1'b0, d, c[0] ? 8 : 32, q);
    endtask
endmodule
`default_nettype wire

// ---- tb/sdc_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checks for the command port and the drive side
module sdc_top_sva #(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link pins and trigger inputs
    input wire logic link_sck,
    input wire logic chip_select_bar,
    input wire logic link_sdo,
    input wire logic link_sdo_oe,
    input wire logic trigger_input_a,
    input wire logic trigger_input_b,
    // Drive side
    input wire logic [NCH-1:0] channel_enable,
    input wire logic outputs_hiz,
    input wire logic [7:0] fault_mask,
    input wire logic [7:0] pair_config,
    input wire logic [NCH*32-1:0] channel_config
);
    logic [2*NCH-1:0] lock_bits;
    // Mode and side bits of every channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            lock_bits[2*i +: 2] = channel_config[32*i +: 2];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Register outputs move only once a frame has closed
    mask_at_end_a: assert property ($changed(fault_mask) |-> chip_select_bar && $past(chip_select_bar, 3))
        else $error("mask changed inside a frame");
    pair_at_end_a: assert property ($changed(pair_config) |-> chip_select_bar && $past(chip_select_bar, 3))
        else $error("pair bits changed inside a frame");
    cfg_at_end_a: assert property ($changed(channel_config) |-> chip_select_bar && $past(chip_select_bar, 3))
        else $error("config changed inside a frame");
    run_at_end_a: assert property ($fell(outputs_hiz) |-> chip_select_bar && $past(chip_select_bar, 3))
        else $error("drive started outside a frame end");
    // Lock bits need idle channels and quiet triggers
    lock_guard_a: assert property ($changed(lock_bits) |->
        $past(channel_enable) == '0 && !$past(trigger_input_a) && !$past(trigger_input_b))
        else $error("mode bits changed while busy");
    // Mode zero: output holds while the clock is high
    sdo_hold_a: assert property ($rose(link_sck) |=> $stable(link_sdo) [*3])
        else $error("serial out moved during clock high");
    oe_idle_a: assert property (chip_select_bar [*4] |-> !link_sdo_oe)
        else $error("serial out driven while deselected");
    oe_busy_a: assert property (!chip_select_bar [*4] |-> link_sdo_oe)
        else $error("serial out released in a frame");
    hiz_gates_a: assert property (outputs_hiz [*3] |-> channel_enable == '0)
        else $error("channel on while outputs idle");
    cover property ($fell(outputs_hiz));
    cover property ($changed(lock_bits));
    cover property ($rose(link_sdo_oe));
endmodule
`default_nettype wire

// ---- tb/sdc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_top_tb;
    import sdc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_sck, chip_select_bar, cmd_select, link_sdi, link_sdo, link_sdo_oe;
    sdc_fault_t chan_faults = '0;
    logic overtemp_in = 1'b0;
    logic trigger_input_a = 1'b0;
    logic trigger_input_b = 1'b0;
    logic undervoltage_in = 1'b0;
    logic [7:0] channel_enable, fault_mask, pair_config, fb;
    logic outputs_hiz, fault_indicator_pin;
    logic [8*32-1:0] channel_config;
    logic [31:0] q;
    int err_count = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    sdc_host sdc_host_inst (.clk(clk), .link_sck(link_sck), .chip_select_bar(chip_select_bar),
        .cmd_select(cmd_select), .link_sdi(link_sdi), .link_sdo(link_sdo));
    // Design under test
    sdc_top sdc_top_inst (.clk(clk), .rst_n(rst_n), .link_sck(link_sck), .chip_select_bar(chip_select_bar),
        .cmd_select(cmd_select), .link_sdi(link_sdi), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
        .chan_faults(chan_faults), .overtemp_in(overtemp_in), .undervoltage_in(undervoltage_in),
        .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b), .channel_enable(channel_enable),
        .outputs_hiz(outputs_hiz), .fault_mask(fault_mask), .pair_config(pair_config),
        .channel_config(channel_config), .fault_indicator_pin(fault_indicator_pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check({outputs_hiz, channel_enable, fault_indicator_pin}, 10'h200);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(fb, 8'h02);
        check(q, SDC_STATUS_RST);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check({fb, fault_indicator_pin}, 9'h001);
        $display("test power-up read done");
        // Flag bits are read-only, so of the low byte only active lands
        sdc_host_inst.acc(8'h80, 32'ha53c5aff, fb, q);
        check({channel_enable, fault_mask, pair_config, outputs_hiz}, 25'h14a78b4);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(fb, 8'h01);
        check(q, 32'ha53c5a01);
        $display("test status write done");
        sdc_host_inst.acc(8'h81, 32'h0f, fb, q);
        check(channel_enable, 8'h0f);
        sdc_host_inst.frame(1'b0, 32'hf0, 8, q);
        check(channel_enable, 8'hf0);
        sdc_host_inst.acc(8'h01, 32'h0, fb, q);
        check(q[7:0], 8'hf0);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(q, 32'hf03c5a01);
        $display("test short access done");
        // Channels on, so the mode bits stay put
        for (int b = 1; b <= 8; b++) begin
            sdc_host_inst.acc(8'h80 | 8'(b << 1), {8'(b), 24'h223303}, fb, q);
            check(channel_config[32*(b-1) +: 32], {8'(b), 24'h223300});
        end
        sdc_host_inst.acc(8'h83, 32'h7e, fb, q);
        check(channel_config[31:0], 32'h7e223300);
        sdc_host_inst.acc(8'h81, 32'h00, fb, q);
        trigger_input_a = 1'b1;
        sdc_host_inst.acc(8'h82, 32'h11223303, fb, q);
        check(channel_config[31:0], 32'h11223300);
        trigger_input_a = 1'b0;
        sdc_host_inst.frame(1'b0, 32'h11223303, 32, q);
        check(channel_config[31:0], 32'h11223303);
        // Second trigger alone also locks the mode and side bits
        trigger_input_b = 1'b1;
        sdc_host_inst.frame(1'b0, 32'h22334400, 32, q);
        check(channel_config[31:0], 32'h22334403);
        trigger_input_b = 1'b0;
        $display("test config done");
        // A short command frame is refused and flagged
        sdc_host_inst.frame(1'b1, 32'h0, 7, q);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(fb, 8'h05);
        check(q, 32'h003c5a05);
        chan_faults.open_load_flag = 8'h10;
        overtemp_in = 1'b1;
        repeat (2) @(negedge clk);
        chan_faults = '0;
        overtemp_in = 1'b0;
        // Overtemperature is unmasked and sticky, so the pin stays low until read
        check(fault_indicator_pin, 1'b0);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(fb, 8'ha1);
        check(fault_indicator_pin, 1'b1);
        // Overcurrent drops its own on bit; detail waits in the fault bank
        sdc_host_inst.acc(8'h81, 32'h04, fb, q);
        check(channel_enable, 8'h04);
        chan_faults.overcurrent_flag = 8'h04;
        @(negedge clk);
        chan_faults = '0;
        @(negedge clk);
        check(channel_enable, 8'h00);
        sdc_host_inst.acc(8'h12, 32'h0, fb, q);
        check(fb, 8'h41);
        check(q, 32'h04001000);
        sdc_host_inst.acc(8'h12, 32'h0, fb, q);
        check(fb, 8'h01);
        check(q, 32'h00000000);
        $display("test faults done");
        // A live undervoltage beats the read clear and keeps the drive idle
        undervoltage_in = 1'b1;
        repeat (2) @(negedge clk);
        check({outputs_hiz, fault_indicator_pin}, 2'h2);
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(fb, 8'h03);
        undervoltage_in = 1'b0;
        sdc_host_inst.acc(8'h00, 32'h0, fb, q);
        check(q, 32'h003c5a03);
        check({outputs_hiz, fault_indicator_pin}, 2'h1);
        $display("test undervoltage done");
        conclude();
    end
endmodule
bind sdc_top sdc_top_sva #(.NCH(NCH)) sdc_top_sva_inst (.clk(clk), .rst_n(rst_n), .link_sck(link_sck),
    .chip_select_bar(chip_select_bar), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
    .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b), .channel_enable(channel_enable),
    .outputs_hiz(outputs_hiz), .fault_mask(fault_mask), .pair_config(pair_config),
    .channel_config(channel_config));
`default_nettype wire
